/* File: fvp_pkg.sv */
package fvp_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam int NREG = 17;
    localparam logic [4:0] REG_FMAX = 5'h00;
    localparam logic [4:0] REG_FBASE = 5'h01;
    localparam logic [4:0] REG_VMAX = 5'h02;
    localparam logic [4:0] REG_FMID = 5'h03;
    localparam logic [4:0] REG_VMID = 5'h04;
    localparam logic [4:0] REG_FMIN = 5'h05;
    localparam logic [4:0] REG_VMIN = 5'h06;
    localparam logic [4:0] REG_ACC1 = 5'h07;
    localparam logic [4:0] REG_DEC1 = 5'h08;
    localparam logic [4:0] REG_ACC2 = 5'h09;
    localparam logic [4:0] REG_DEC2 = 5'h0A;
    localparam logic [4:0] REG_JACC = 5'h0B;
    localparam logic [4:0] REG_JDEC = 5'h0C;
    localparam logic [4:0] REG_JOGF = 5'h0D;
    localparam logic [4:0] REG_LIMIT = 5'h0E;
    localparam logic [4:0] REG_MODE = 5'h0F;
    localparam logic [4:0] REG_INFUNC = 5'h10;
    localparam logic [4:0] REG_STAT = 5'h11;

    typedef logic [15:0] fvp_word_t;

    // ------------------------------------------------------------
    // Reset values and legal ranges of the plain settings
    // ------------------------------------------------------------
    localparam fvp_word_t RST_VAL [NREG] = '{
        16'h2710, 16'h1770, 16'h0898, 16'h0064, 16'h0078, 16'h0064,
        16'h0078, 16'h0064, 16'h0064, 16'h03E8, 16'h03E8, 16'h03E8,
        16'h03E8, 16'h0258, 16'h0064, 16'h0000, 16'h0000};
    localparam fvp_word_t MIN_VAL [NREG] = '{
        16'h1388, 16'h03E8, 16'h0014, 16'h0064, 16'h0014, 16'h0064,
        16'h0014, 16'h000A, 16'h000A, 16'h000A, 16'h000A, 16'h000A,
        16'h0000, 16'h0064, 16'h0000, 16'h0000, 16'h0000};
    localparam fvp_word_t MAX_VAL [NREG] = '{
        16'h9C40, 16'h9C40, 16'h09F6, 16'h9C40, 16'h09F6, 16'h1770,
        16'h09F6, 16'hEA60, 16'hEA60, 16'hEA60, 16'hEA60, 16'hEA60,
        16'hEA60, 16'h9C40, 16'hFFFF, 16'hFFFF, 16'hFFFF};

    // ------------------------------------------------------------
    // Field layouts and codes
    // ------------------------------------------------------------
    localparam int UL_LSB = 0;
    localparam int LL_LSB = 8;
    localparam logic [7:0] UL_MIN = 8'h01;
    localparam logic [7:0] UL_MAX = 8'h6E;
    localparam logic [7:0] LL_MAX = 8'h64;
    localparam int MODE_LSB = 0;
    localparam int ACCS_LSB = 4;
    localparam int DECS_LSB = 8;
    localparam logic [2:0] MODE_MAX = 3'h5;
    localparam int FUNC_W = 5;
    localparam logic [4:0] FUNC_JOG = 5'h0A;
    localparam logic [4:0] FUNC_SET2 = 5'h07;
    localparam logic [23:0] PCT_RECIP = 24'hA3_D70B;
    localparam int PCT_SHIFT = 30;

    // ------------------------------------------------------------
    // Timing: one setting step of ramp time is 10 ms
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int TSTEP_NS = 10_000_000;
    localparam int TICKS_PER_TSTEP = TSTEP_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_JOG, ST_JOGSTOP} fvp_state_e;

    typedef struct packed {
        logic [11:0] base;
        logic [27:0] num;
        logic [15:0] den;
    } fvp_seg_s;

    typedef struct packed {
        logic dir_rev;
        fvp_state_e state;
        logic [11:0] volt;
        logic [15:0] freq;
    } fvp_stat_s;

endpackage

/* File: fvp_div.sv */
`timescale 1ns/1ps
module fvp_div import fvp_pkg::*; #(
    parameter int NW = 28,
    parameter int DW = 16
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Request
    input wire logic start,
    input wire logic [NW-1:0] num,
    input wire logic [DW-1:0] den,
    // Answer
    output logic [NW-1:0] quo,
    output logic done
);
    logic [DW-1:0] rem_r;
    logic [5:0] cnt_r;
    logic busy_r;
    wire [DW:0] trial = {rem_r, quo[NW-1]};
    wire fits = trial >= {1'b0, den};
    wire [DW:0] diff = trial - {1'b0, den};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quo <= '0;
            rem_r <= '0;
            cnt_r <= '0;
            busy_r <= 1'b0;
            done <= 1'b0;
        end else if (start && !busy_r) begin
            quo <= num;
            rem_r <= '0;
            cnt_r <= 6'(NW);
            busy_r <= 1'b1;
            done <= 1'b0;
        end else if (busy_r) begin
            rem_r <= fits ? diff[DW-1:0] : trial[DW-1:0];
            quo <= {quo[NW-2:0], fits};
            cnt_r <= cnt_r - 6'd1;
            busy_r <= cnt_r != 6'd1;
            done <= cnt_r == 6'd1;
        end else begin
            done <= 1'b0;
        end
    end
endmodule

/* File: fvp_ramp_top.sv */
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
// How it works
// R01 - Max frequency setting scales every command
// R02 - Software keeps voltage and frequency points ordered
// R03 - Max voltage setting caps the profile
// R04 - Mid frequency sets the lower slope
// R05 - Mid voltage pairs with mid frequency; here exactly at a mid frequency above min frequency the output is max voltage
// R06 - Min frequency is low vertex, jog start
// R07 - Min voltage applies at min frequency
// R08 - Upper and lower limits in percent
// R09 - Run clamped between lower and upper limit
// R10 - Accel time spans zero to max frequency
// R11 - Decel time spans max frequency to zero
// R12 - Second time set while its input closed
// R13 - Jog input ramps from min to jog
// R14 - Jog release ramps down to zero
// R15 - Jog uses its own ramp times
// R16 - Jog ignored during normal run
// R17 - While jogging only keypad keys count
// R18 - Ramp mode selects linear or automatic
// R19 - Shaping zero linear, one to seven S; here one to seven only stretch a linear ramp
// R20 - Higher shaping lengthens the ramp
// R21 - Voltage interpolated between vertices, capped above
module fvp_ramp_top import fvp_pkg::*; #(
    parameter int unsigned TICKS = TICKS_PER_TSTEP
) (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Commands
    input wire logic run_cmd,
    input wire logic [15:0] cmd_frac,
    input wire logic [2:0] programmable_inputs,
    input wire logic key_fwd,
    input wire logic key_rev,
    input wire logic key_stop,
    input wire logic stall_hold,
    // Drive outputs
    output logic [15:0] freq_out,
    output logic [11:0] volt_out,
    output logic dir_rev,
    output logic running,
    output logic jogging
);
    // ------------------------------------------------------------
    // Settings store and APB access
    // ------------------------------------------------------------
    fvp_word_t cfg_r [NREG];
    fvp_state_e state_r;
    logic [31:0] prdata_nxt;
    logic stop_lat_r;
    fvp_word_t new_w_q;

    wire setup = psel && !penable && !pready;
    wire [4:0] idx = paddr[6:2];
    wire mapped = paddr[11:7] == 5'h00 && idx <= REG_STAT;
    wire is_cfg = idx < REG_STAT;
    wire [4:0] widx = is_cfg ? idx : 5'h00;
    wire fvp_word_t old_w = cfg_r[widx];
    wire fvp_word_t new_w = {pstrb[1] ? pwdata[15:8] : old_w[15:8],
                             pstrb[0] ? pwdata[7:0] : old_w[7:0]};
    wire [7:0] new_ul = new_w[UL_LSB +: 8];
    wire [7:0] new_ll = new_w[LL_LSB +: 8];
    wire lim_ok = new_ul >= UL_MIN && new_ul <= UL_MAX && new_ll <= LL_MAX;
    wire mode_ok = new_w[MODE_LSB +: 3] <= MODE_MAX && new_w[15:11] == 5'h00 &&
                   new_w[7] == 1'b0 && new_w[3] == 1'b0;
    wire range_ok = new_w >= MIN_VAL[widx] && new_w <= MAX_VAL[widx];
    // Out-of-range writes are refused so the store only ever holds legal values.
    wire val_ok = widx == REG_LIMIT ? lim_ok : // R08
                  widx == REG_MODE ? mode_ok : range_ok; // R01
    wire wr_bad = pwrite && (!is_cfg || !val_ok);
    wire do_wr = psel && penable && pready && pwrite && !pslverr;

    wire fvp_stat_s stat = '{dir_rev: dir_rev, state: state_r,
                              volt: volt_out, freq: freq_out};
    assign prdata_nxt = !mapped ? 32'h0000_0000 :
                        is_cfg ? {16'h0000, old_w} :
                        {1'b0, stat};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup && (!mapped || wr_bad);
            prdata <= setup && !pwrite ? prdata_nxt : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r <= RST_VAL;
        end else if (do_wr) begin
            cfg_r[widx] <= new_w_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            new_w_q <= 16'h0000;
        end else if (setup) begin
            new_w_q <= new_w;
        end
    end

    // ------------------------------------------------------------
    // Limits and command scaling
    // ------------------------------------------------------------
    wire [15:0] fmax = cfg_r[REG_FMAX];
    wire [23:0] fm_ul = fmax * cfg_r[REG_LIMIT][UL_LSB +: 8];
    wire [23:0] fm_ll = fmax * cfg_r[REG_LIMIT][LL_LSB +: 8];
    wire [47:0] hi_p = fm_ul * PCT_RECIP; // R08
    wire [47:0] lo_p = fm_ll * PCT_RECIP;
    wire [31:0] cmd_p = fmax * cmd_frac; // R01
    logic [15:0] lim_hi_r;
    logic [15:0] lim_lo_r;
    logic [15:0] cmd_f_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lim_hi_r <= 16'h0000;
            lim_lo_r <= 16'h0000;
            cmd_f_r <= 16'h0000;
        end else begin
            lim_hi_r <= hi_p[PCT_SHIFT +: 16];
            lim_lo_r <= lo_p[PCT_SHIFT +: 16];
            cmd_f_r <= cmd_p[31:16];
        end
    end

    // ------------------------------------------------------------
    // Input functions and run state
    // ------------------------------------------------------------
    logic [2:0] in_jog;
    logic [2:0] in_set2;
    for (genvar i = 0; i < 3; i++) begin : g_in
        wire [4:0] fn = cfg_r[REG_INFUNC][i*FUNC_W +: FUNC_W];
        assign in_jog[i] = programmable_inputs[i] && fn == FUNC_JOG; // R13
        assign in_set2[i] = programmable_inputs[i] && fn == FUNC_SET2; // R12
    end
    wire jog_in = |in_jog;
    wire sel2 = |in_set2;

    wire [15:0] run_lo = cmd_f_r < lim_lo_r ? lim_lo_r : cmd_f_r; // R09
    wire [15:0] run_tgt = run_lo > lim_hi_r ? lim_hi_r : run_lo; // R09
    wire [15:0] jogf = cfg_r[REG_JOGF];
    wire [15:0] jog_tgt = jogf > lim_hi_r ? lim_hi_r : jogf; // R13
    wire [15:0] fmin = cfg_r[REG_FMIN];
    wire [15:0] jog_start = fmin > jog_tgt ? jog_tgt : fmin; // R06
    wire run_on = run_cmd && !stop_lat_r;
    wire [15:0] tgt = state_r == ST_RUN && run_on ? run_tgt :
                      state_r == ST_JOG ? jog_tgt : 16'h0000; // R14
    wire at_zero = freq_out == 16'h0000;
    fvp_state_e state_nxt;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (run_on) begin
                    state_nxt = ST_RUN;
                end else if (jog_in) begin
                    state_nxt = ST_JOG; // R13
                end
            end
            // A jog request while running is simply not looked at.
            ST_RUN: begin
                if (!run_on && at_zero) begin
                    state_nxt = ST_IDLE; // R16
                end
            end
            // Only the jog input and the keypad keys act here; run_cmd is not looked at.
            ST_JOG: begin
                if (!jog_in || key_stop) begin
                    state_nxt = ST_JOGSTOP; // R17
                end
            end
            ST_JOGSTOP: begin
                if (at_zero) begin
                    state_nxt = ST_IDLE; // R14
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            stop_lat_r <= 1'b0;
            dir_rev <= 1'b0;
            running <= 1'b0;
            jogging <= 1'b0;
        end else begin
            state_r <= state_nxt;
            stop_lat_r <= key_stop || (stop_lat_r && run_cmd);
            dir_rev <= key_rev ? 1'b1 : key_fwd ? 1'b0 : dir_rev; // R17
            running <= state_nxt != ST_IDLE;
            jogging <= state_nxt == ST_JOG || state_nxt == ST_JOGSTOP;
        end
    end

    // ------------------------------------------------------------
    // Ramp time selection and shaping
    // ------------------------------------------------------------
    wire up = freq_out < tgt;
    wire dn = freq_out > tgt;
    wire in_jog_st = state_r == ST_JOG || state_r == ST_JOGSTOP;
    wire [15:0] t_norm = up ? cfg_r[sel2 ? REG_ACC2 : REG_ACC1] :
                         cfg_r[sel2 ? REG_DEC2 : REG_DEC1]; // R12
    wire [15:0] t_jog = up ? cfg_r[REG_JACC] : cfg_r[REG_JDEC]; // R15
    wire [15:0] t_sel = in_jog_st ? t_jog : t_norm; // R15
    wire [2:0] mode = cfg_r[REG_MODE][MODE_LSB +: 3];
    // No load feedback reaches this block, so automatic ramps take half time.
    wire auto_acc = mode == 3'h1 || mode == 3'h3 || mode == 3'h5; // R18
    wire auto_dec = mode >= 3'h2; // R18
    wire stall_on = mode >= 3'h4; // R18
    wire auto_now = up ? auto_acc : auto_dec;
    wire [15:0] t_base = auto_now ? {1'b0, t_sel[15:1]} : t_sel; // R18
    wire [2:0] shape = up ? cfg_r[REG_MODE][ACCS_LSB +: 3] :
                       cfg_r[REG_MODE][DECS_LSB +: 3];
    wire [18:0] t_bs = t_base * shape;
    // Shaping 0 adds nothing; each further step adds one eighth of the time.
    wire [17:0] t_eff = 18'(t_base) + 18'(t_bs[18:3]); // R19 R20
    wire [49:0] thr = t_eff * 50'(TICKS); // R10 R11

    // ------------------------------------------------------------
    // Ramp engine: one 0.01 Hz step each time fmax worth of credit fills thr
    // ------------------------------------------------------------
    logic [49:0] acc_r;
    wire [49:0] acc_n = acc_r + 50'(fmax);
    wire hold = dn && stall_on && stall_hold; // R18
    wire moving = (up || dn) && !hold;
    wire step = moving && acc_n >= thr; // R10 R11
    wire jog_enter = state_r == ST_IDLE && state_nxt == ST_JOG;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_r <= '0;
            freq_out <= 16'h0000;
        end else begin
            acc_r <= !moving || jog_enter ? 50'h0 : step ? acc_n - thr : acc_n;
            if (jog_enter) begin
                freq_out <= jog_start; // R13
            end else if (step) begin
                freq_out <= up ? freq_out + 16'h0001 : freq_out - 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // Voltage profile
    // ------------------------------------------------------------
    wire [15:0] fbase = cfg_r[REG_FBASE];
    wire [15:0] fmid = cfg_r[REG_FMID];
    wire [11:0] vmax = cfg_r[REG_VMAX][11:0];
    wire [11:0] vmid = cfg_r[REG_VMID][11:0];
    wire [11:0] vmin = cfg_r[REG_VMIN][11:0];
    // Saturating differences keep a misordered profile from wrapping.
    wire [11:0] dv_lo = vmid > vmin ? vmid - vmin : 12'h000; // R02
    wire [11:0] dv_hi = vmax > vmid ? vmax - vmid : 12'h000; // R02
    wire [15:0] df_lo = fmid - fmin;
    wire [15:0] df_hi = fbase - fmid;
    wire [15:0] fo_lo = freq_out - fmin;
    wire [15:0] fo_hi = freq_out - fmid;
    wire [27:0] n_lo = dv_lo * fo_lo; // R04 R05
    wire [27:0] n_hi = dv_hi * fo_hi;
    wire seg1 = freq_out > fmin && freq_out < fmid;
    wire seg2 = !seg1 && freq_out > fmid && freq_out < fbase;
    wire fvp_seg_s seg = seg1 ? fvp_seg_s'{base: vmin, num: n_lo, den: df_lo} :
                         seg2 ? fvp_seg_s'{base: vmid, num: n_hi, den: df_hi} :
                         freq_out <= fmin ? fvp_seg_s'{base: vmin, num: 28'h0, den: 16'h1} :
                         fvp_seg_s'{base: vmax, num: 28'h0, den: 16'h1}; // R21 R06 R07
    fvp_seg_s seg_r;
    logic vf_busy_r;
    logic [27:0] quo;
    logic div_done;
    wire [27:0] v_sum = 28'(seg_r.base) + quo;

    fvp_div #(.NW(28), .DW(16)) u_div (
        .pclk(pclk),
        .presetn(presetn),
        .start(!vf_busy_r),
        .num(seg.num),
        .den(seg.den),
        .quo(quo),
        .done(div_done)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seg_r <= '0;
            vf_busy_r <= 1'b0;
            volt_out <= 12'h000;
        end else begin
            if (!vf_busy_r) begin
                seg_r <= seg;
            end
            vf_busy_r <= !div_done && (vf_busy_r || 1'b1);
            if (div_done) begin
                volt_out <= v_sum > 28'(vmax) ? vmax : v_sum[11:0]; // R03 R21
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_bad_setup;
        setup && mapped && wr_bad;
    endsequence
    sequence s_jog_go;
        state_r == ST_IDLE && !run_on && jog_in;
    endsequence

    a_bad_write_kept: assert property (s_bad_setup |=> // R01
        pslverr && pready ##1 cfg_r[$past(widx, 2)] == $past(old_w, 2))
        else $error("refused write changed a setting");
    a_jog_from_min: assert property (s_jog_go |=> // R13
        state_r == ST_JOG && freq_out == $past(jog_start))
        else $error("jog did not start at minimum frequency");
    a_no_jog_in_run: assert property (state_r == ST_RUN |=> state_r != ST_JOG) // R16
        else $error("jog entered from normal run");
    a_jog_keeps: assert property (state_r == ST_JOG && jog_in && !key_stop |=> // R17
        state_r == ST_JOG)
        else $error("jog left without release or stop key");
    a_jog_release: assert property (state_r == ST_JOG && !jog_in |=> // R14
        state_r == ST_JOGSTOP && tgt == 16'h0000)
        else $error("jog release did not ramp to zero");
    a_run_clamped: assert property (state_r == ST_RUN && run_on |-> // R09
        tgt <= lim_hi_r && tgt >= (lim_lo_r > lim_hi_r ? lim_hi_r : lim_lo_r))
        else $error("run target outside limits");
    a_step_one: assert property (!jog_enter |=> // R10
        freq_out - $past(freq_out) <= 16'h0001 || $past(freq_out) - freq_out <= 16'h0001)
        else $error("ramp moved more than one step");
    a_rate_spaced: assert property (step && thr > 50'(fmax) * 2 |=> !step) // R11
        else $error("ramp stepped faster than its time allows");
    a_set2_used: assert property (!in_jog_st && up && sel2 |-> t_sel == cfg_r[REG_ACC2]) // R12
        else $error("second accel time not used");
    a_stall_holds: assert property (hold [*2] |-> $stable(freq_out)) // R18
        else $error("decel continued during stall hold");
    a_shape_longer: assert property (shape != 3'h0 && t_base >= 16'h0008 |-> // R20
        t_eff > 18'(t_base))
        else $error("shaping did not lengthen ramp");
    a_volt_capped: assert property (div_done |=> volt_out <= $past(vmax)) // R03
        else $error("voltage above maximum");
    a_apb_answer: assert property (setup |=> pready ##1 !pready)
        else $error("APB answer not one cycle after setup");
endmodule

/* File: fvp_inputs_model.sv */
`timescale 1ns/1ps
module fvp_inputs_model (
    // Clock
    input wire logic pclk,
    // Requests from the bench
    input wire logic jog_on,
    input wire logic set2_on,
    input wire logic [1:0] key_req,
    // Terminals and keypad
    output logic [2:0] programmable_inputs = 3'h0,
    output logic key_fwd = 1'b0,
    output logic key_rev = 1'b0,
    output logic key_stop = 1'b0
);
    // Input 0 is wired as jog, input 1 as time set 2; input 2 stays open.
    always @(posedge pclk) begin
        programmable_inputs <= {1'b0, set2_on, jog_on};
        key_fwd <= (key_req == 2'd1);
        key_rev <= (key_req == 2'd2);
        key_stop <= (key_req == 2'd3);
    end
endmodule

/* File: fvp_ramp_top_tb.sv */
`timescale 1ns/1ps
module fvp_ramp_top_tb;
    import fvp_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic run_cmd = 1'b0;
    logic jog_on = 1'b0;
    logic set2_on = 1'b0;
    logic [15:0] cmd_frac = 16'h0000;
    logic [1:0] key_req = 2'h0;
    logic stall_hold = 1'b0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, kf, kr, ks, dir_rev, running, jogging;
    logic [2:0] pins;
    logic [15:0] freq_out;
    logic [11:0] volt_out;
    int num_errors = 0;
    int checks_done = 0;
    int n;
    int ka [8] = '{4, 8, 2, 4, 2, 4, 2, 6};
    int kd [8] = '{4, 8, 4, 2, 3, 2, 2, 4};
    logic [15:0] mw [8] = '{16'h0000, 16'h0000, 16'h0001, 16'h0002, 16'h0403, 16'h0004,
        16'h0005, 16'h0040};

    always #2.5 pclk = ~pclk;

    fvp_inputs_model fvp_inputs_model_inst (.pclk(pclk), .jog_on(jog_on), .set2_on(set2_on),
        .key_req(key_req), .programmable_inputs(pins), .key_fwd(kf), .key_rev(kr),
        .key_stop(ks));
    // TICKS of 5 keeps ramps short, yet no ramp needs more than one step per clock.
    fvp_ramp_top #(.TICKS(5)) fvp_ramp_top_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr), .run_cmd(run_cmd),
        .cmd_frac(cmd_frac), .programmable_inputs(pins), .key_fwd(kf), .key_rev(kr),
        .key_stop(ks), .stall_hold(stall_hold), .freq_out(freq_out), .volt_out(volt_out),
        .dir_rev(dir_rev), .running(running), .jogging(jogging));

    // ----------
    // Shared tasks
    // ----------
    task automatic give_verdict;
        $display("mismatches %0d of %0d checks", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check_val(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic near(input logic [31:0] seen, input logic [31:0] exp);
        check_val({31'h0, (seen + exp / 20 + 4 >= exp) && (seen <= exp + exp / 20 + 4)}, 32'h1);
    endtask

    task automatic apb(input logic wr, input logic [4:0] idx, input logic [15:0] d);
        int k;
        paddr <= {5'h00, idx, 2'b00};
        pwrite <= wr;
        pwdata <= {16'h0000, d};
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        if (k >= 20) begin
            num_errors++;
            give_verdict();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wait_freq(input logic [15:0] f);
        n = 0;
        while (freq_out !== f && n < 30000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 30000) begin
            num_errors++;
            give_verdict();
        end
    endtask

    // ----------
    // Main sequence
    // ----------
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < NREG; i++) begin
            apb(1'b0, 5'(i), 16'h0000);
            check_val(rd, {16'h0000, RST_VAL[i]});
        end
        apb(1'b1, REG_FMAX, 16'h1387);
        check_val({31'h0, err}, 32'h1);
        apb(1'b1, REG_LIMIT, 16'h006F);
        check_val({31'h0, err}, 32'h1);
        apb(1'b0, 5'h12, 16'h0000);
        check_val({31'h0, err}, 32'h1);
        apb(1'b1, REG_FMAX, 16'h1388);
        check_val({31'h0, err}, 32'h0);
        apb(1'b1, REG_ACC1, 16'h07D0);
        apb(1'b1, REG_DEC1, 16'h07D0);
        apb(1'b1, REG_ACC2, 16'h0FA0);
        apb(1'b1, REG_DEC2, 16'h0FA0);
        apb(1'b1, REG_JACC, 16'h07D0);
        apb(1'b1, REG_JDEC, 16'h07D0);
        apb(1'b1, REG_INFUNC, 16'h00EA);
        cmd_frac <= 16'h2000;
        // Each case times the span 125 to 625; one quarter factor is 250 cycles.
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, REG_MODE, mw[c]);
            apb(1'b0, REG_MODE, 16'h0000);
            check_val(rd, {16'h0000, mw[c]});
            set2_on <= (c == 1);
            repeat (3) @(posedge pclk);
            run_cmd <= 1'b1;
            wait_freq(16'd125);
            wait_freq(16'd625);
            near(n, 250 * ka[c]);
            run_cmd <= 1'b0;
            wait_freq(16'd125);
            near(n, 250 * kd[c]);
            if (c == 5) begin
                stall_hold <= 1'b1;
                repeat (20) @(posedge pclk);
                check_val(freq_out, 32'd124);
                stall_hold <= 1'b0;
            end
            wait_freq(16'd0);
            repeat (3) @(posedge pclk);
        end
        set2_on <= 1'b0;
        apb(1'b1, REG_MODE, 16'h0000);
        apb(1'b1, REG_LIMIT, 16'h1432);
        cmd_frac <= 16'h0000;
        run_cmd <= 1'b1;
        wait_freq(16'd1000);
        repeat (60) @(posedge pclk);
        check_val(freq_out, 32'd1000);
        check_val(running, 32'h1);
        near(volt_out, 32'd437);
        jog_on <= 1'b1;
        repeat (10) @(posedge pclk);
        check_val(jogging, 32'h0);
        jog_on <= 1'b0;
        cmd_frac <= 16'hFFFF;
        wait_freq(16'd2500);
        repeat (60) @(posedge pclk);
        check_val(freq_out, 32'd2500);
        near(volt_out, 32'd966);
        apb(1'b1, REG_FBASE, 16'h07D0);
        repeat (60) @(posedge pclk);
        check_val(volt_out, 32'd2200);
        key_req <= 2'd3;
        @(posedge pclk);
        key_req <= 2'd0;
        wait_freq(16'd0);
        run_cmd <= 1'b0;
        repeat (3) @(posedge pclk);
        jog_on <= 1'b1;
        n = 0;
        while (jogging !== 1'b1 && n < 10) begin
            @(posedge pclk);
            n++;
        end
        check_val(jogging, 32'h1);
        check_val(freq_out, 32'd100);
        wait_freq(16'd600);
        near(n, 32'd1000);
        run_cmd <= 1'b1;
        key_req <= 2'd2;
        @(posedge pclk);
        key_req <= 2'd0;
        repeat (4) @(posedge pclk);
        apb(1'b0, REG_STAT, 16'h0000);
        check_val(rd[29:28], 32'h2);
        check_val(dir_rev, 32'h1);
        key_req <= 2'd1;
        @(posedge pclk);
        key_req <= 2'd0;
        repeat (3) @(posedge pclk);
        check_val(dir_rev, 32'h0);
        run_cmd <= 1'b0;
        jog_on <= 1'b0;
        wait_freq(16'd0);
        near(n, 32'd1200);
        give_verdict();
    end
endmodule
